// ===== pkg/sfcd_defines.vh
/*
  constants for the serial flash command decoder: opcodes, geometry,
  status layout, reset values and timing counts.
  assumes a 20 MHz system clock and a 20-bit (1 MByte) array.
*/
`ifndef SFCD_DEFINES_VH
`define SFCD_DEFINES_VH

`define SFCD_OP_READ 8'h03
`define SFCD_OP_FAST_READ 8'h0B
`define SFCD_OP_SECTOR_ERASE 8'h20
`define SFCD_OP_BLOCK32_ERASE 8'h52
`define SFCD_OP_BLOCK64_ERASE 8'hD8
`define SFCD_OP_CHIP_ERASE_A 8'h60
`define SFCD_OP_CHIP_ERASE_B 8'hC7
`define SFCD_OP_BYTE_PROGRAM 8'h02
`define SFCD_OP_AUTO_INC 8'hAD
`define SFCD_OP_STATUS_READ 8'h05
`define SFCD_OP_WRITE_LATCH_SET 8'h06
`define SFCD_OP_WRITE_LATCH_CLR 8'h04
`define SFCD_OP_ID_READ_A 8'h90
`define SFCD_OP_ID_READ_B 8'hAB
`define SFCD_OP_BUSY_ON 8'h70
`define SFCD_OP_BUSY_OFF 8'h80

`define SFCD_ADDR_W 20
`define SFCD_TOP_ADDRESS_BIT 19
`define SFCD_SECTOR_LSB 12
`define SFCD_BLOCK32_LSB 15
`define SFCD_BLOCK64_LSB 16
`define SFCD_ERASED_BYTE 8'hFF

`define SFCD_ST_BUSY 0
`define SFCD_ST_WEL 1
`define SFCD_ST_AUTO_INC 6
`define SFCD_PROT_RESET 4'h7

`define SFCD_CLK_MHZ 20
`define SFCD_BYTE_PROGRAM_TIME_NS 7000
`define SFCD_BYTE_PROGRAM_CYCLES ((`SFCD_BYTE_PROGRAM_TIME_NS * `SFCD_CLK_MHZ + 999) / 1000)
`define SFCD_ERASE_TIME_US 18000
`define SFCD_ERASE_CYCLES (`SFCD_ERASE_TIME_US * `SFCD_CLK_MHZ)

`endif

// ===== core/sfcd_pin_sync.v
/*
  two flip-flop synchroniser for the serial pins, plus edge detection
  done on the second and third stages, never on the first.
  assumes the pins are asynchronous to mclk_in.
*/
`default_nettype none
module sfcd_pin_sync (
  input wire mclk_in,
  input wire rst_in,
  input wire sck_in,
  input wire cs_n_in,
  input wire si_in,
  output reg sck_rise_out,
  output reg sck_fall_out,
  output reg cs_n_out,
  output reg cs_fall_out,
  output reg cs_rise_out,
  output reg si_out
);
  reg [2:0] meta_reg;
  reg [2:0] sync_reg;
  reg [2:0] hist_reg;
  always @(posedge mclk_in) begin
    if (rst_in) begin
      meta_reg <= 3'h2;
      sync_reg <= 3'h2;
      hist_reg <= 3'h2;
      sck_rise_out <= 1'b0;
      sck_fall_out <= 1'b0;
      cs_n_out <= 1'b1;
      cs_fall_out <= 1'b0;
      cs_rise_out <= 1'b0;
      si_out <= 1'b0;
    end else begin
      meta_reg <= {sck_in, cs_n_in, si_in};
      sync_reg <= meta_reg;
      // edges compare settled stages only, never the metastable first flop
      hist_reg <= sync_reg;
      sck_rise_out <= sync_reg[2] & ~hist_reg[2];
      sck_fall_out <= ~sync_reg[2] & hist_reg[2];
      cs_fall_out <= ~sync_reg[1] & hist_reg[1];
      cs_rise_out <= sync_reg[1] & ~hist_reg[1];
      cs_n_out <= sync_reg[1];
      si_out <= sync_reg[0];
    end
  end
endmodule // sfcd_pin_sync
`default_nettype wire

// ===== core/sfcd_decoder.v
/*
  serial flash command decoder: samples the host pins, decodes opcode,
  address, dummy and data cycles, drives the serial output and issues
  memory read, program and erase requests to an array outside.
  assumes the array answers mem_rdata_in combinationally from
  mem_raddr_out within one mclk cycle, far faster than one bit.
*/
// What this block does
// - 03H plus three address bytes reads
// - 0BH adds one dummy byte before data
// - reads stream incrementing until chip select rises
// - read pointer wraps from top to zero
// - 20H erases sector chosen by bits 12+
// - 52H erases 32K block, bits 15+
// - D8H erases 64K block, bits 16+
// - 60H or C7H erases whole array
// - 02H, address, one data byte programs
// - program into protected region is ignored
// - program starts on chip select rise
// - busy stays set until operation ends
// - ADH, address, two bytes: even then odd
// - ADH without address continues next word
// - 05H repeats status byte until deselect
// - 90H/ABH ID read, bit 0 selects code
// - 70H/80H switch busy shown on output in ADH mode
// - every bus cycle is eight clocks
// - address bits above top are ignored
// - falling select frames, rising clock samples
// - early deselect aborts command in progress
// - write latch clears when write completes, except in ADH mode
`default_nettype none
`include "sfcd_defines.vh"
module sfcd_decoder #(
  parameter PROG_CYCLES = `SFCD_BYTE_PROGRAM_CYCLES,
  parameter ERASE_CYCLES = `SFCD_ERASE_CYCLES,
  parameter [7:0] MAKER_CODE = 8'hA5,
  parameter [7:0] PART_CODE = 8'h5A
) (
  input wire mclk_in,
  input wire rst_in,
  input wire sck_in,
  input wire cs_n_in,
  input wire si_in,
  input wire [3:0] protect_level_in,
  input wire [7:0] mem_rdata_in,
  output reg so_out,
  output reg so_oe_out,
  output reg [19:0] mem_raddr_out,
  output reg mem_wr_out,
  output reg [19:0] mem_waddr_out,
  output reg [7:0] mem_wdata_out,
  output reg mem_erase_out,
  output reg [19:0] mem_erase_base_out,
  output reg [19:0] mem_erase_size_out,
  output reg busy_out,
  output reg write_enable_latch_out,
  output reg auto_increment_program_out,
  output reg ready_busy_mode_out
);
  // maker and part codes are arbitrary neutral values
  localparam S_OPCODE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_DUMMY = 3'h2;
  localparam S_DATA = 3'h3;
  localparam S_OUT = 3'h4;
  localparam S_IGNORE = 3'h5;

  localparam K_NONE = 3'h0;
  localparam K_READ = 3'h1;
  localparam K_PROG = 3'h2;
  localparam K_AUTO = 3'h3;
  localparam K_ERASE = 3'h4;
  localparam K_STATUS = 3'h5;
  localparam K_ID = 3'h6;

  wire sck_rise;
  wire sck_fall;
  wire cs_n;
  wire cs_fall;
  wire cs_rise;
  wire si;

  reg [2:0] state_reg;
  reg [2:0] kind_reg;
  reg [2:0] bit_reg;
  reg [1:0] byte_reg;
  reg [7:0] shift_reg;
  reg [23:0] addr_reg;
  reg [7:0] data0_reg;
  reg [7:0] data1_reg;
  reg [1:0] data_cnt_reg;
  reg [7:0] opcode_reg;
  reg [7:0] out_reg;
  reg [31:0] timer_reg;
  reg [19:0] auto_addr_reg;
  reg auto_second_reg;
  reg [19:0] erase_base_reg;
  reg [19:0] erase_size_reg;
  reg erase_pend_reg;
  reg out_load_reg;

  wire [7:0] rx_byte = {shift_reg[6:0], si};
  wire byte_done = sck_rise && (bit_reg == 3'h7) && !cs_n;
  wire [7:0] status_byte = {1'b0, auto_increment_program_out, 2'h0,
    protect_level_in[1:0], write_enable_latch_out, busy_out};

  // lowest protected address for a protection level
  function [20:0] prot_floor;
    input [3:0] lvl;
    begin
      case (lvl[2:0])
        3'h0: prot_floor = 21'h100000;
        3'h1: prot_floor = 21'h0F0000;
        3'h2: prot_floor = 21'h0E0000;
        3'h3: prot_floor = 21'h0C0000;
        3'h4: prot_floor = 21'h080000;
        default: prot_floor = 21'h000000;
      endcase
    end
  endfunction

  function is_protected;
    input [19:0] a;
    input [3:0] lvl;
    begin
      is_protected = ({1'b0, a} >= prot_floor(lvl));
    end
  endfunction

  sfcd_pin_sync u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .sck_in(sck_in),
    .cs_n_in(cs_n_in),
    .si_in(si_in),
    .sck_rise_out(sck_rise),
    .sck_fall_out(sck_fall),
    .cs_n_out(cs_n),
    .cs_fall_out(cs_fall),
    .cs_rise_out(cs_rise),
    .si_out(si)
  );

  // address currently used by streamed output
  // top bits dropped
  wire [19:0] addr20 = addr_reg[`SFCD_TOP_ADDRESS_BIT:0];

  always @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg <= S_OPCODE;
      kind_reg <= K_NONE;
      bit_reg <= 3'h0;
      byte_reg <= 2'h0;
      shift_reg <= 8'h00;
      addr_reg <= 24'h000000;
      data0_reg <= 8'h00;
      data1_reg <= 8'h00;
      data_cnt_reg <= 2'h0;
      opcode_reg <= 8'h00;
      out_reg <= 8'h00;
      out_load_reg <= 1'b0;
      timer_reg <= 32'h00000000;
      auto_addr_reg <= 20'h00000;
      auto_second_reg <= 1'b0;
      erase_base_reg <= 20'h00000;
      erase_size_reg <= 20'h00000;
      erase_pend_reg <= 1'b0;
      so_out <= 1'b0;
      so_oe_out <= 1'b0;
      mem_raddr_out <= 20'h00000;
      mem_wr_out <= 1'b0;
      mem_waddr_out <= 20'h00000;
      mem_wdata_out <= 8'h00;
      mem_erase_out <= 1'b0;
      mem_erase_base_out <= 20'h00000;
      mem_erase_size_out <= 20'h00000;
      busy_out <= 1'b0;
      write_enable_latch_out <= 1'b0;
      auto_increment_program_out <= 1'b0;
      ready_busy_mode_out <= 1'b0;
    end else begin
      mem_wr_out <= 1'b0;
      mem_erase_out <= 1'b0;
      out_load_reg <= 1'b0;
      if (busy_out) begin
        if (timer_reg <= 32'h00000001) begin
          busy_out <= 1'b0;
          if (!auto_increment_program_out) begin
            write_enable_latch_out <= 1'b0;
          end
          if (erase_pend_reg) begin
            erase_pend_reg <= 1'b0;
          end
        end else begin
          timer_reg <= timer_reg - 32'h00000001;
        end
      end
      if (cs_fall) begin
        state_reg <= S_OPCODE;
        kind_reg <= K_NONE;
        bit_reg <= 3'h0;
        byte_reg <= 2'h0;
        data_cnt_reg <= 2'h0;
        if (ready_busy_mode_out && auto_increment_program_out) begin
          so_oe_out <= 1'b1;
          so_out <= ~busy_out;
        end
      end else if (cs_rise) begin
        so_oe_out <= 1'b0;
        if (bit_reg == 3'h0 && !busy_out && write_enable_latch_out) begin
          if (kind_reg == K_PROG && data_cnt_reg == 2'h1) begin
            if (!is_protected(addr20, protect_level_in)) begin
              mem_wr_out <= 1'b1;
              mem_waddr_out <= addr20;
              mem_wdata_out <= data0_reg;
              busy_out <= 1'b1;
              timer_reg <= PROG_CYCLES;
            end
          end else if (kind_reg == K_AUTO && data_cnt_reg == 2'h2) begin
            if (!is_protected(auto_addr_reg, protect_level_in)) begin
              mem_wr_out <= 1'b1;
              mem_waddr_out <= {auto_addr_reg[19:1], 1'b0};
              mem_wdata_out <= data0_reg;
              auto_second_reg <= 1'b1;
              auto_increment_program_out <= 1'b1;
              busy_out <= 1'b1;
              timer_reg <= PROG_CYCLES;
            end
          end else if (kind_reg == K_ERASE && state_reg == S_IGNORE) begin
            if (erase_size_reg == 20'h00000 ? protect_level_in[2:0] == 3'h0
                : !is_protected(erase_base_reg, protect_level_in)) begin
              mem_erase_out <= 1'b1;
              mem_erase_base_out <= erase_base_reg;
              mem_erase_size_out <= erase_size_reg;
              erase_pend_reg <= 1'b1;
              busy_out <= 1'b1;
              timer_reg <= ERASE_CYCLES;
            end
          end
        end
        state_reg <= S_OPCODE;
        kind_reg <= K_NONE;
        bit_reg <= 3'h0;
      end else begin
        if (auto_second_reg) begin
          auto_second_reg <= 1'b0;
          mem_wr_out <= 1'b1;
          mem_waddr_out <= {auto_addr_reg[19:1], 1'b1};
          mem_wdata_out <= data1_reg;
          auto_addr_reg <= {auto_addr_reg[19:1] + 19'h00001, 1'b0};
        end
        if (out_load_reg) begin
          if (kind_reg == K_ID) begin
            out_reg <= addr_reg[0] ? PART_CODE : MAKER_CODE;
          end else if (kind_reg == K_STATUS) begin
            out_reg <= status_byte;
          end else begin
            out_reg <= mem_rdata_in;
            addr_reg <= {4'h0, addr20 + 20'h00001};
          end
        end
        if (sck_fall && state_reg == S_OUT) begin
          so_oe_out <= 1'b1;
          so_out <= out_reg[7];
          out_reg <= {out_reg[6:0], 1'b0};
        end
        if (sck_rise && !cs_n) begin
          bit_reg <= bit_reg + 3'h1;
          shift_reg <= rx_byte;
        end
        if (byte_done) begin
          case (state_reg)
            S_OPCODE: begin
              opcode_reg <= rx_byte;
              byte_reg <= 2'h0;
              if (busy_out && rx_byte != `SFCD_OP_STATUS_READ) begin
                state_reg <= S_IGNORE;
              end else begin
                case (rx_byte)
                  `SFCD_OP_READ: begin
                    kind_reg <= K_READ;
                    state_reg <= S_ADDR;
                  end
                  `SFCD_OP_FAST_READ: begin
                    kind_reg <= K_READ;
                    state_reg <= S_ADDR;
                  end
                  `SFCD_OP_SECTOR_ERASE, `SFCD_OP_BLOCK32_ERASE,
                  `SFCD_OP_BLOCK64_ERASE: begin
                    kind_reg <= K_ERASE;
                    state_reg <= S_ADDR;
                  end
                  `SFCD_OP_CHIP_ERASE_A, `SFCD_OP_CHIP_ERASE_B: begin
                    kind_reg <= K_ERASE;
                    erase_base_reg <= 20'h00000;
                    erase_size_reg <= 20'h00000;
                    state_reg <= S_IGNORE;
                  end
                  `SFCD_OP_BYTE_PROGRAM: begin
                    kind_reg <= K_PROG;
                    state_reg <= S_ADDR;
                  end
                  `SFCD_OP_AUTO_INC: begin
                    kind_reg <= K_AUTO;
                    state_reg <= auto_increment_program_out ? S_DATA : S_ADDR;
                  end
                  `SFCD_OP_STATUS_READ: begin
                    kind_reg <= K_STATUS;
                    state_reg <= S_OUT;
                    out_load_reg <= 1'b1;
                  end
                  `SFCD_OP_ID_READ_A, `SFCD_OP_ID_READ_B: begin
                    kind_reg <= K_ID;
                    state_reg <= S_ADDR;
                  end
                  `SFCD_OP_WRITE_LATCH_SET: begin
                    write_enable_latch_out <= 1'b1;
                    state_reg <= S_IGNORE;
                  end
                  `SFCD_OP_WRITE_LATCH_CLR: begin
                    write_enable_latch_out <= 1'b0;
                    auto_increment_program_out <= 1'b0;
                    state_reg <= S_IGNORE;
                  end
                  `SFCD_OP_BUSY_ON: begin
                    ready_busy_mode_out <= 1'b1;
                    state_reg <= S_IGNORE;
                  end
                  `SFCD_OP_BUSY_OFF: begin
                    ready_busy_mode_out <= 1'b0;
                    state_reg <= S_IGNORE;
                  end
                  default: begin
                    kind_reg <= K_NONE;
                    state_reg <= S_IGNORE;
                  end
                endcase
              end
            end
            S_ADDR: begin
              addr_reg <= {addr_reg[15:0], rx_byte};
              byte_reg <= byte_reg + 2'h1;
              if (byte_reg == 2'h2) begin
                byte_reg <= 2'h0;
                if (kind_reg == K_READ && opcode_reg == `SFCD_OP_FAST_READ) begin
                  state_reg <= S_DUMMY;
                end else if (kind_reg == K_READ || kind_reg == K_ID) begin
                  state_reg <= S_OUT;
                  out_load_reg <= 1'b1;
                  mem_raddr_out <= {addr_reg[11:0], rx_byte};
                end else if (kind_reg == K_ERASE) begin
                  state_reg <= S_IGNORE;
                  case (opcode_reg)
                    `SFCD_OP_SECTOR_ERASE: begin
                      erase_base_reg <= {addr_reg[11:4], 12'h000};
                      erase_size_reg <= 20'h01000;
                    end
                    `SFCD_OP_BLOCK32_ERASE: begin
                      erase_base_reg <= {addr_reg[11:7], 15'h0000};
                      erase_size_reg <= 20'h08000;
                    end
                    default: begin
                      erase_base_reg <= {addr_reg[11:8], 16'h0000};
                      erase_size_reg <= 20'h10000;
                    end
                  endcase
                end else begin
                  state_reg <= S_DATA;
                  auto_addr_reg <= {addr_reg[11:0], rx_byte};
                end
              end
            end
            S_DUMMY: begin
              state_reg <= S_OUT;
              out_load_reg <= 1'b1;
              mem_raddr_out <= addr20;
            end
            S_DATA: begin
              if (data_cnt_reg == 2'h0) begin
                data0_reg <= rx_byte;
              end else begin
                data1_reg <= rx_byte;
              end
              if (data_cnt_reg != 2'h3) begin
                data_cnt_reg <= data_cnt_reg + 2'h1;
              end
            end
            S_OUT: begin
              out_load_reg <= 1'b1;
              mem_raddr_out <= addr20;
            end
            default: begin
              state_reg <= S_IGNORE;
            end
          endcase
        end
      end
    end
  end
endmodule // sfcd_decoder
`default_nettype wire

// ===== bench/sfcd_checker.sv
/*
  port assertions for the flash command decoder.
  assumes one clock domain with a synchronous active-high reset.
*/
`default_nettype none
module sfcd_checker #(
  parameter PROG_CYCLES = 140,
  parameter ERASE_CYCLES = 50
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic [3:0] protect_level_in,
  input wire logic so_oe_out,
  input wire logic mem_wr_out,
  input wire logic [19:0] mem_waddr_out,
  input wire logic mem_erase_out,
  input wire logic [19:0] mem_erase_base_out,
  input wire logic [19:0] mem_erase_size_out,
  input wire logic busy_out,
  input wire logic write_enable_latch_out,
  input wire logic auto_increment_program_out
);
  // a word program holds busy for one byte time only; the upper bound still allows twice the longer time
  localparam int LO = ((PROG_CYCLES < ERASE_CYCLES) ? PROG_CYCLES : ERASE_CYCLES) - 2;
  localparam int HI = 2 * ((PROG_CYCLES < ERASE_CYCLES) ? ERASE_CYCLES : PROG_CYCLES) + 2;
  logic [31:0] busy_len_reg;
  always @(posedge mclk_in) begin
    if (rst_in || !busy_out) begin
      busy_len_reg <= 32'h0;
    end else begin
      busy_len_reg <= busy_len_reg + 32'h1;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  oe_idle_a: assert property (cs_n_in [*5] |-> !so_oe_out)
    else $error("output enabled while deselected");
  wr_after_cs_a: assert property (mem_wr_out |-> cs_n_in && $past(cs_n_in))
    else $error("write before select rose");
  wr_latch_a: assert property (mem_wr_out |-> $past(write_enable_latch_out))
    else $error("write without latch");
  wr_prot_a: assert property (mem_wr_out |-> protect_level_in[2:0] < 3'h5)
    else $error("write with all blocks protected");
  word_pair_a: assert property (mem_wr_out ##1 mem_wr_out |->
    mem_waddr_out[0] && mem_waddr_out == $past(mem_waddr_out) + 20'h1)
    else $error("word bytes out of order");
  erase_align_a: assert property (mem_erase_out |->
    (mem_erase_base_out & (mem_erase_size_out - 20'h1)) == 20'h0)
    else $error("erase base not aligned");
  erase_size_a: assert property (mem_erase_out |->
    mem_erase_size_out inside {20'h01000, 20'h08000, 20'h10000, 20'h00000})
    else $error("erase size unknown");
  busy_start_a: assert property ((mem_wr_out || mem_erase_out) |=> busy_out)
    else $error("busy missing after write");
  busy_len_a: assert property ($fell(busy_out) |-> busy_len_reg >= LO && busy_len_reg <= HI)
    else $error("busy length wrong");
  latch_clear_a: assert property ($fell(busy_out) && !auto_increment_program_out |->
    ##[0:1] !write_enable_latch_out)
    else $error("latch kept after write");
  cover property (mem_erase_out);
  cover property (mem_wr_out ##1 mem_wr_out);
  cover property ($rose(so_oe_out));
endmodule // sfcd_checker
bind sfcd_decoder sfcd_checker #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) chk (
  .mclk_in, .rst_in, .cs_n_in, .protect_level_in, .so_oe_out, .mem_wr_out, .mem_waddr_out,
  .mem_erase_out, .mem_erase_base_out, .mem_erase_size_out, .busy_out,
  .write_enable_latch_out, .auto_increment_program_out);
`default_nettype wire

// ===== bench/sfcd_host.sv
/*
  serial host model: frames commands with select, clocks bytes msb first.
  assumes the bench calls its tasks from one process at a time.
*/
`default_nettype none
module sfcd_host (
  input wire logic mclk_in,
  input wire logic so_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  task automatic sel(input logic on);
    @(posedge mclk_in);
    cs_n_out <= ~on;
    // released line must not keep a stale level
    si_out <= ~si_out;
    repeat (8) @(posedge mclk_in);
  endtask
  // eight 400 ns clocks a byte
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      si_out <= tx[i];
      repeat (4) @(posedge mclk_in);
      @(negedge mclk_in);
      rx[i] = so_in;
      @(posedge mclk_in);
      sck_out <= 1'b1;
      repeat (3) @(posedge mclk_in);
      sck_out <= 1'b0;
    end
  endtask
endmodule // sfcd_host
`default_nettype wire

// ===== bench/testbench.sv
/*
  self-checking bench for the flash command decoder.
  assumes the host model on the pins and a pattern array answering reads.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // id codes are arbitrary
  localparam logic [7:0] MK = 8'h3C;
  localparam logic [7:0] PK = 8'hC3;
  localparam logic [7:0] OPS [5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
  localparam logic [19:0] SZ [5] = '{20'h01000, 20'h08000, 20'h10000, 20'h0, 20'h0};
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] prot = 4'h0;
  logic [7:0] rdata;
  wire logic sck, cs_n, si, so, so_oe, wr, er, busy, write_enable_latch, aip, rbm;
  wire logic [19:0] raddr, waddr, ebase, esize;
  wire logic [7:0] wdata;
  // a released output shows the inverse, so a missing enable is caught
  wire logic so_line = so_oe ? so : ~so;
  int fails = 0;
  int samples_checked = 0;
  logic [7:0] rx[$];
  logic [39:0] wq[$];
  logic [39:0] eq[$];
  logic [23:0] a;
  logic [7:0] d;
  always #25 mclk_in = ~mclk_in;
  function automatic logic [7:0] pat(input logic [19:0] x);
    return x[7:0] ^ x[19:12];
  endfunction
  always @* rdata = pat(raddr);
  always @(posedge mclk_in) begin
    if (wr === 1'b1) wq.push_back({12'h0, waddr, wdata});
    if (er === 1'b1) eq.push_back({esize, ebase});
  end
  sfcd_decoder #(.ERASE_CYCLES(50), .MAKER_CODE(MK), .PART_CODE(PK)) DUT (
    .mclk_in(mclk_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .protect_level_in(prot), .mem_rdata_in(rdata), .so_out(so), .so_oe_out(so_oe),
    .mem_raddr_out(raddr), .mem_wr_out(wr), .mem_waddr_out(waddr), .mem_wdata_out(wdata),
    .mem_erase_out(er), .mem_erase_base_out(ebase), .mem_erase_size_out(esize),
    .busy_out(busy), .write_enable_latch_out(write_enable_latch), .auto_increment_program_out(aip),
    .ready_busy_mode_out(rbm));
  sfcd_host host (.mclk_in(mclk_in), .so_in(so_line), .sck_out(sck), .cs_n_out(cs_n), .si_out(si));
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [7:0] b[$], input int n);
    logic [7:0] v;
    rx.delete();
    host.sel(1'b1);
    foreach (b[i]) host.xfer(b[i], 8, v);
    repeat (n) begin
      host.xfer(8'h00, 8, v);
      rx.push_back(v);
    end
    host.sel(1'b0);
  endtask
  task automatic idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 2000) fails++;
  endtask
  task automatic close_out;
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk_in);
    fails++;
    close_out;
  end
  initial begin
    a = 24'($urandom(32'h6710));
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    cmp({busy, write_enable_latch, aip, rbm, so_oe}, 40'h0);
    // junk above the top address bit
    a = 24'hFFFFFE;
    run('{8'h03, a[23:16], a[15:8], a[7:0]}, 4);
    for (int i = 0; i < 4; i++) cmp(rx[i], pat(a[19:0] + 20'(i)));
    a = 24'($urandom);
    run('{8'h0B, a[23:16], a[15:8], a[7:0], 8'hA5}, 3);
    for (int i = 0; i < 3; i++) cmp(rx[i], pat(a[19:0] + 20'(i)));
    for (int k = 0; k < 4; k++) begin
      run('{k[1] ? 8'hAB : 8'h90, 8'h00, 8'h00, 8'(k[0])}, 2);
      cmp({rx[0], rx[1]}, k[0] ? {PK, PK} : {MK, MK});
    end
    d = 8'($urandom);
    run('{8'h02, a[23:16], a[15:8], a[7:0], d}, 0);
    idle;
    cmp(wq.size(), 0);
    prot <= 4'h5;
    run('{8'h06}, 0);
    run('{8'h05}, 2);
    cmp({rx[0], rx[1]}, 16'h0606);
    run('{8'h02, a[23:16], a[15:8], a[7:0], d}, 0);
    idle;
    cmp(wq.size(), 0);
    prot <= 4'h0;
    run('{8'h06}, 0);
    // target byte taken as erased
    run('{8'h02, a[23:16], a[15:8], a[7:0], d}, 0);
    cmp(busy, 1);
    idle;
    cmp(wq.pop_front(), {a[19:0], d});
    cmp(write_enable_latch, 0);
    run('{8'h06}, 0);
    host.sel(1'b1);
    for (int i = 0; i < 4; i++) host.xfer(i ? a[7:0] : 8'h02, 8, d);
    host.xfer(8'h3A, 5, d);
    host.sel(1'b0);
    run('{8'hFF, 8'h02, a[15:8]}, 1);
    run('{8'h20, a[15:8]}, 0);
    run('{8'h05}, 1);
    cmp(rx[0], 8'h02);
    idle;
    cmp(wq.size(), 0);
    cmp(eq.size(), 0);
    for (int k = 0; k < 5; k++) begin
      a = 24'($urandom);
      run('{8'h06}, 0);
      if (k < 3) run('{OPS[k], a[23:16], a[15:8], a[7:0]}, 0);
      else run('{OPS[k]}, 0);
      idle;
      cmp(eq.pop_front(), {SZ[k], k < 3 ? a[19:0] & ~(SZ[k] - 20'h1) : 20'h0});
      cmp(write_enable_latch, 0);
    end
    run('{8'h70}, 0);
    cmp(rbm, 1);
    a = 24'($urandom) | 24'h1;
    run('{8'h06}, 0);
    run('{8'hAD, a[23:16], a[15:8], a[7:0], 8'h11, 8'h22}, 0);
    // busy word program shows low on the output from select on
    host.sel(1'b1);
    host.xfer(8'h00, 8, d);
    host.sel(1'b0);
    cmp(d, 8'h00);
    idle;
    cmp(aip, 1);
    run('{8'hAD, 8'h33, 8'h44}, 0);
    idle;
    host.sel(1'b1);
    host.xfer(8'h00, 8, d);
    host.sel(1'b0);
    cmp(d, 8'hFF);
    run('{8'h04}, 0);
    cmp(aip, 0);
    for (int i = 0; i < 4; i++) cmp(wq.pop_front(), {20'({a[19:1], 1'b0} + i), 8'(8'h11 * (i + 1))});
    run('{8'h80}, 0);
    cmp(rbm, 0);
    close_out;
  end
endmodule // testbench
`default_nettype wire
